// ===== hw/eprom_prog_pkg.sv
package eprom_prog_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 18;

    // ------------------------------------------------------------
    // Timing in its own units, then in clk_sys cycles
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int T_ACCESS_NS    = 300;
    localparam int T_SETUP_NS     = 2000;
    localparam int T_HOLD_NS      = 2000;
    localparam int T_VPP_HOLD_NS  = 2000;
    localparam int T_PULSE_US     = 10000;
    localparam int T_PULSE_MIN_US = 9000;
    localparam int T_PULSE_MAX_US = 44000;

    // Least times round up, longest times round down
    localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VPP_HOLD_CYC  = (T_VPP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_NOM_CYC = T_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int PULSE_MIN_CYC = (T_PULSE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = T_PULSE_MAX_US * 1000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Reset values of the pins
    // ------------------------------------------------------------
    localparam logic STROBE_RST = 1'b1;
    localparam logic VPP_RST    = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_PG_SETUP,
        ST_PG_PULSE,
        ST_PG_HOLD,
        ST_PG_VPP_OFF
    } state_t;

endpackage

// ===== hw/eprom_prog_ctrl.sv
`timescale 1ns/1ps

// Operation
// RL1: Read: strobe low, normal supply, byte out
// RL2: Strobe high outside programming: outputs float
// RL3: Erased locations read back all ones
// RL4: Programming only clears bits to zero
// RL5: Program only with high programming supply
// RL6: Programmer drives byte on data pins
// RL7: One strobe pulse 9 to 44 ms
// RL8: Locations programmable in any order
// RL9: Unselected devices keep strobe high, inhibited
// RL10: Verify by read once supply normal
// RL11: 4096 locations of eight bits
module eprom_prog_ctrl
    import eprom_prog_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_NOM_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              cmd_read,
    input  wire logic              cmd_program,
    input  wire logic              program_select,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic                   verify_fail,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   powerdown_program_strobe,
    output logic                   vpp_high_en,
    input  wire logic [DATA_W-1:0] byte_lines_in,
    output logic [DATA_W-1:0]      byte_lines_out,
    output logic                   byte_lines_oe
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        state_t            st;
        logic [CNT_W-1:0]  cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              strobe;
        logic              vpp;
        logic              oe;
        logic [DATA_W-1:0] rdata;
        logic              done;
        logic              fail;
        logic              sel;
        logic              verify;
        logic              busy;
    } regs_t;

    regs_t r;
    regs_t nxt;

    always_comb begin
        nxt      = r;
        nxt.done = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                // Any address may be taken whenever idle
                if (cmd_program) begin // RL8
                    nxt.addr   = addr_in;
                    nxt.data   = wdata_in;
                    nxt.sel    = program_select;
                    nxt.vpp    = 1'b1; // RL5
                    nxt.oe     = 1'b1; // RL6
                    nxt.fail   = 1'b0;
                    nxt.busy   = 1'b1;
                    nxt.cnt    = CNT_W'(SETUP_CYC - 1);
                    nxt.st     = ST_PG_SETUP;
                end else if (cmd_read) begin
                    nxt.addr   = addr_in;
                    nxt.strobe = 1'b0; // RL1
                    nxt.verify = 1'b0;
                    nxt.fail   = 1'b0;
                    nxt.busy   = 1'b1;
                    nxt.cnt    = CNT_W'(ACCESS_CYC - 1);
                    nxt.st     = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                if (r.cnt == '0) begin
                    nxt.rdata  = byte_lines_in; // RL1
                    nxt.strobe = 1'b1; // RL2
                    // Readback must match; a one that stays zero is unrecoverable
                    if (r.verify) begin
                        nxt.fail = (byte_lines_in != r.data); // RL4
                    end
                    nxt.done   = 1'b1;
                    nxt.busy   = 1'b0;
                    nxt.st     = ST_IDLE;
                end else begin
                    nxt.cnt = r.cnt - 1'b1;
                end
            end
            ST_PG_SETUP: begin
                if (r.cnt == '0) begin
                    // Unselected device sees no pulse at all
                    nxt.strobe = ~r.sel; // RL9
                    nxt.cnt    = CNT_W'(PULSE_CYC - 1);
                    nxt.st     = ST_PG_PULSE;
                end else begin
                    nxt.cnt = r.cnt - 1'b1;
                end
            end
            ST_PG_PULSE: begin
                if (r.cnt == '0) begin
                    nxt.strobe = 1'b1; // RL7
                    nxt.cnt    = CNT_W'(HOLD_CYC - 1);
                    nxt.st     = ST_PG_HOLD;
                end else begin
                    nxt.cnt = r.cnt - 1'b1;
                end
            end
            ST_PG_HOLD: begin
                if (r.cnt == '0) begin
                    nxt.oe  = 1'b0;
                    nxt.vpp = 1'b0;
                    nxt.cnt = CNT_W'(VPP_HOLD_CYC - 1);
                    nxt.st  = ST_PG_VPP_OFF;
                end else begin
                    nxt.cnt = r.cnt - 1'b1;
                end
            end
            ST_PG_VPP_OFF: begin
                if (r.cnt == '0) begin
                    if (r.sel) begin
                        // Verify read follows directly at normal supply
                        nxt.strobe = 1'b0; // RL10
                        nxt.verify = 1'b1;
                        nxt.cnt    = CNT_W'(ACCESS_CYC - 1);
                        nxt.st     = ST_RD_WAIT;
                    end else begin
                        nxt.done = 1'b1;
                        nxt.busy = 1'b0;
                        nxt.st   = ST_IDLE;
                    end
                end else begin
                    nxt.cnt = r.cnt - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r        <= '0;
            r.st     <= ST_IDLE;
            r.strobe <= STROBE_RST;
            r.vpp    <= VPP_RST;
        end else begin
            r <= nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy                     = r.busy;
    assign done                     = r.done;
    assign rdata                    = r.rdata;
    assign verify_fail              = r.fail;
    assign addr_out                 = r.addr;
    assign powerdown_program_strobe = r.strobe;
    assign vpp_high_en              = r.vpp;
    assign byte_lines_out           = r.data;
    assign byte_lines_oe            = r.oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence rd_start_s;
        r.st == ST_IDLE && cmd_read && !cmd_program;
    endsequence

    sequence vpp_off_end_s;
        r.st == ST_PG_VPP_OFF && r.cnt == '0 && r.sel;
    endsequence

    sequence pulse_start_s;
        $fell(r.strobe) && r.vpp;
    endsequence

    read_level_a: assert property (r.st == ST_RD_WAIT |-> !r.strobe && !r.vpp && !r.oe) // RL1
        else $error("read without strobe low at normal supply");

    read_time_a: assert property (rd_start_s |-> ##9 (r.done && r.strobe)) // RL1
        else $error("read not finished after access time");

    bus_free_a: assert property (!r.vpp |-> !r.oe) // RL2
        else $error("data pins driven outside programming");

    prog_supply_a: assert property ((r.vpp && !r.strobe) |-> r.st == ST_PG_PULSE && r.oe) // RL5
        else $error("strobe low with high supply outside pulse");

    prog_data_a: assert property (r.st == ST_PG_PULSE |-> r.oe && r.vpp && byte_lines_out == r.data) // RL6
        else $error("byte not presented during pulse");

    // Width limits rest on PULSE_CYC; short simulation values fall outside them
    pulse_len_a: assert property (pulse_start_s |-> r.st == ST_PG_PULSE && r.cnt == CNT_W'(PULSE_CYC - 1)) // RL7
        else $error("program pulse not loaded with its length");

    pulse_count_a: assert property ((r.st == ST_PG_PULSE && r.cnt != '0) // RL7
                                     |=> r.st == ST_PG_PULSE && r.cnt == $past(r.cnt) - 1'b1
                                     && r.strobe == $past(r.strobe))
        else $error("program pulse cut short");

    pulse_end_a: assert property ((r.st == ST_PG_PULSE && r.cnt == '0) |=> r.strobe && r.st == ST_PG_HOLD) // RL7
        else $error("program pulse not ended");

    any_order_a: assert property ((r.st == ST_IDLE && cmd_program) |=> r.st == ST_PG_SETUP
                                   && r.addr == $past(addr_in)) // RL8
        else $error("program request not accepted");

    inhibit_a: assert property ((r.st == ST_PG_PULSE && !r.sel) |-> r.strobe) // RL9
        else $error("inhibited device pulsed");

    verify_read_a: assert property (vpp_off_end_s |=> r.st == ST_RD_WAIT && !r.vpp && !r.strobe && r.verify) // RL10
        else $error("verify read not started after supply drop");

endmodule

// ===== tb/eprom_model.sv
`timescale 1ns/1ps
// ----
// Array and pins
// ----
module eprom_model
    import eprom_prog_pkg::*;
#(
    parameter int MIN_CYC = 1,
    parameter int MAX_CYC = 1000
) (
    input  wire logic              clk_sys,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              strobe,
    input  wire logic              vpp_high,
    input  wire logic [DATA_W-1:0] d_in,
    output logic [DATA_W-1:0]      q,
    output logic                   q_oe,
    output int                     bad_pulses
);
    logic [DATA_W-1:0] mem [0:4095];
    int                low_cnt;
    initial begin
        for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
        low_cnt = 0;
        bad_pulses = 0;
        q = 8'h00;
    end
    assign q_oe = !strobe && !vpp_high;
    // Floating pins toggle so a stale value never reads as good
    always @(posedge clk_sys) q <= q_oe ? mem[addr] : ~q;
    always @(posedge clk_sys) begin
        low_cnt <= (vpp_high && !strobe) ? low_cnt + 1 : 0;
        if (vpp_high && strobe && low_cnt != 0) begin
            if (low_cnt < MIN_CYC || low_cnt > MAX_CYC) bad_pulses <= bad_pulses + 1;
            mem[addr] <= mem[addr] & d_in;
        end
    end
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
    import eprom_prog_pkg::*;
;
    localparam int P = 20;
    logic clk_sys, rst, cmd_read, cmd_program, program_select;
    logic [ADDR_W-1:0] addr_in, addr_out;
    logic [DATA_W-1:0] wdata_in, rdata, byte_lines_in, byte_lines_out, dev_q;
    logic busy, done, verify_fail, strobe, vpp, byte_lines_oe, dev_oe, cur_unsel;
    int fails, checked, seed, bad_pulses, ref_mem [4096];
    assign byte_lines_in = byte_lines_oe ? byte_lines_out : dev_q;
    eprom_prog_ctrl #(.PULSE_CYC(P)) dut (.clk_sys(clk_sys), .rst(rst), .cmd_read(cmd_read),
        .cmd_program(cmd_program), .program_select(program_select), .addr_in(addr_in),
        .wdata_in(wdata_in), .busy(busy), .done(done), .rdata(rdata), .verify_fail(verify_fail),
        .addr_out(addr_out), .powerdown_program_strobe(strobe), .vpp_high_en(vpp),
        .byte_lines_in(byte_lines_in), .byte_lines_out(byte_lines_out), .byte_lines_oe(byte_lines_oe));
    eprom_model #(.MIN_CYC(P), .MAX_CYC(P)) dev (.clk_sys(clk_sys), .addr(addr_out), .strobe(strobe),
        .vpp_high(vpp), .d_in(byte_lines_in), .q(dev_q), .q_oe(dev_oe), .bad_pulses(bad_pulses));
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----
    // One command, with a refused command while busy
    // ----
    task automatic op(input logic prog, input logic sel, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cmd_program = prog;
        cmd_read = !prog;
        program_select = sel;
        addr_in = a;
        wdata_in = d;
        cur_unsel = prog && !sel;
        @(posedge clk_sys) #1;
        chk(busy, 1'b1);
        {cmd_read, cmd_program} = 2'b00;
        addr_in = ~a;
        while (done !== 1'b1 && n < 400) begin
            n++;
            cmd_read = (n == 3);
            @(posedge clk_sys) #1;
        end
        chk(n + 1, !prog ? ACCESS_CYC + 1 : SETUP_CYC + P + HOLD_CYC + VPP_HOLD_CYC
            + (sel ? ACCESS_CYC + 1 : 1));
        if (!prog) chk(rdata, ref_mem[a]);
        if (prog && sel) begin
            ref_mem[a] = ref_mem[a] & d;
            chk(rdata, ref_mem[a]);
            chk(verify_fail, ref_mem[a] != d);
        end
        @(posedge clk_sys) #1;
        chk(busy, 1'b0);
        cur_unsel = 0;
    endtask
    // Pin conflicts and inhibit watched every cycle
    always @(posedge clk_sys) if (!rst) begin
        if (byte_lines_oe && dev_oe) chk(1, 0);
        if (!strobe && byte_lines_oe) chk(vpp, 1'b1);
        if (cur_unsel) chk(strobe, 1'b1);
    end
    initial begin
        #(40 * 20000);
        fails++;
        close_out();
    end
    initial begin
        {cmd_read, cmd_program, program_select, cur_unsel, fails, checked} = 0;
        {addr_in, wdata_in} = 0;
        seed = 41;
        foreach (ref_mem[i]) ref_mem[i] = 8'hff;
        rst = 1;
        repeat (6) @(posedge clk_sys);
        #1 rst = 0;
        op(0, 0, 12'h000, 8'h00);
        op(0, 0, 12'hfff, 8'h00);
        repeat (4) op(0, 0, 12'($random(seed)), 8'h00);
        $display("test erased done");
        op(1, 1, 12'hfff, 8'h5a);
        op(1, 1, 12'h000, 8'ha5);
        op(1, 1, 12'h000, 8'hff);
        repeat (8) op(1, 1, 12'($random(seed)) & 12'h00f, 8'($random(seed)));
        $display("test program done");
        op(1, 0, 12'hfff, 8'h00);
        op(0, 0, 12'hfff, 8'h00);
        $display("test inhibit done");
        for (int i = 0; i < 16; i++) op(0, 0, 12'(i), 8'h00);
        chk(bad_pulses, 0);
        chk(PULSE_NOM_CYC >= PULSE_MIN_CYC && PULSE_NOM_CYC <= PULSE_MAX_CYC, 1'b1);
        $display("test verify done");
        close_out();
    end
endmodule
